// >>> verilog/boot_ctl_map.svh
`ifndef BOOT_CTL_MAP_SVH
`define BOOT_CTL_MAP_SVH
// pin level codes per boot mode pin, as a pair {is_float, level}
`define PIN_LOW          2'h0
`define PIN_HIGH         2'h1
`define PIN_FLOAT        2'h2
// boot mode codes, three pin codes packed msb pin first
`define CODE_SYNC_MUX    6'h20
`define CODE_ASYNC_MUX   6'h21
`define CODE_USB_ONLY    6'h25
`define CODE_ASYNC_SRAM  6'h22
`define CODE_I2C_USB     6'h26
`define CODE_I2C_ONLY    6'h1a
`define CODE_SPI_USB     6'h09
// settle time after weak pull is applied, in ns, and its cycle count at 20 MHz
`define PROBE_SETTLE_NS  200
`define CLK_PERIOD_NS    50
`define PROBE_CYCLES     ((`PROBE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset stretch for a whole-device soft reset, in cycles
`define SOFT_HOLD_CYCLES 4
// bits of the processor port init control word
`define INIT_CPU_BIT     0
`define INIT_DEV_BIT     1
`endif

// >>> verilog/boot_ctl_pkg.sv
package boot_ctl_pkg;
    typedef enum logic [2:0] {
        BOOT_NONE       = 3'b000,
        BOOT_SYNC_MUX   = 3'b001,
        BOOT_ASYNC_MUX  = 3'b010,
        BOOT_ASYNC_SRAM = 3'b011,
        BOOT_USB        = 3'b100,
        BOOT_I2C        = 3'b101,
        BOOT_SPI        = 3'b110
    } boot_src_type;

    typedef struct packed {
        boot_src_type src;      // primary source
        logic         usb_fb;   // usb fallback on failure
        logic         valid;    // code was a listed one
    } boot_mode_type;
endpackage : boot_ctl_pkg

// >>> verilog/pin_sync3.sv
`timescale 1ns/1ps
// three-flop synchroniser; a change is taken once stages two and three agree
module pin_sync3 (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_r, s2_r, s3_r;   // chain; s1 only feeds s2

    // sample chain
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // filtered output moves only on agreement
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            q_o <= 1'b0;
        end else if (s2_r == s3_r) begin
            q_o <= s3_r;
        end
    end
endmodule : pin_sync3

// >>> verilog/boot_source_and_reset_control.sv
//Contract
//- boot source chosen from three tri-level pins
//- F00 sync mux, F01 async mux, F0F sram
//- F11 usb only, 1FF i2c only
//- F1F i2c then usb on failure
//- 0F1 spi then usb on failure
//- all io tristated during hard reset
//- loader configures io by decoded mode afterwards
//- cpu reset restarts pc, keeps firmware
//- device soft reset acts as hard reset
`timescale 1ns/1ps
`include "boot_ctl_map.svh"
module boot_source_and_reset_control
    import boot_ctl_pkg::*;
(
    input  wire logic       clk_sys_i,           // 20 MHz core clock
    input  wire logic       rst_n_i,             // hard reset pin, sync, active low
    input  wire logic [2:0] boot_mode_pins_i,    // pad level of the mode pins
    input  wire logic [1:0] processor_port_init_control_i, // soft reset request bits
    input  wire logic       loader_done_i,       // loader reports image loaded
    input  wire logic       loader_fail_i,       // loader reports primary failed
    output logic [2:0]      mode_pull_en_o,      // weak pull enable on mode pins
    output logic [2:0]      mode_pull_up_o,      // pull direction, 1 = up
    output logic            io_oe_allow_o,       // gate on all io output enables
    output logic            cpu_rst_n_o,         // processor reset, active low
    output logic            fw_valid_o,          // firmware present in memory
    output boot_mode_type   boot_mode_o,         // decoded mode, held
    output boot_src_type    active_src_o,        // source loader is using now
    output logic            loader_run_o         // loader owns the io
);

////////////////////////////////////////////////////////////////////////////////
// synchronise pads
    logic [2:0] pin_s;   // filtered mode pins
    logic       req_cpu_s;
    logic       req_dev_s;

    for (genvar g = 0; g < 3; g++) begin : g_pin
        pin_sync3 u_sync (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .d_i       (boot_mode_pins_i[g]),
            .q_o       (pin_s[g])
        );
    end
    // requests come from processor logic on this clock, no sync needed
    assign req_cpu_s = processor_port_init_control_i[`INIT_CPU_BIT];
    assign req_dev_s = processor_port_init_control_i[`INIT_DEV_BIT];

////////////////////////////////////////////////////////////////////////////////
// decode helper
    function automatic boot_mode_type decode_mode(input logic [5:0] code);
        boot_mode_type m;
        m = '{src: BOOT_NONE, usb_fb: 1'b0, valid: 1'b1};
        case (code)
            `CODE_SYNC_MUX:   m.src = BOOT_SYNC_MUX;
            `CODE_ASYNC_MUX:  m.src = BOOT_ASYNC_MUX;
            `CODE_ASYNC_SRAM: m.src = BOOT_ASYNC_SRAM;
            `CODE_USB_ONLY:   m.src = BOOT_USB;
            `CODE_I2C_ONLY:   m.src = BOOT_I2C;
            `CODE_I2C_USB: begin
                m.src    = BOOT_I2C;
                m.usb_fb = 1'b1;
            end
            `CODE_SPI_USB: begin
                m.src    = BOOT_SPI;
                m.usb_fb = 1'b1;
            end
            default: m.valid = 1'b0;                   // unlisted: no boot
        endcase
        return m;
    endfunction : decode_mode

////////////////////////////////////////////////////////////////////////////////
// sequencer: probe pins high, probe low, then run loader
    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_PROBEH = 3'b001,
        ST_PROBEL = 3'b010,
        ST_LOAD   = 3'b011,
        ST_RUN    = 3'b100,
        ST_HOLD   = 3'b101
    } seq_state_type;

    seq_state_type seq_r;
    logic [3:0]    cnt_r;       // settle / hold counter
    logic [2:0]    hi_r;        // pin level with pull-up
    logic          fb_used_r;   // fallback already taken

    localparam logic [3:0] PROBE_N = 4'(`PROBE_CYCLES);
    localparam logic [3:0] HOLD_N  = 4'(`SOFT_HOLD_CYCLES);

    // main sequence; device soft reset re-enters probing like a hard reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            seq_r <= ST_RESET;
            cnt_r <= 4'h0;
        end else begin
            case (seq_r)
                ST_RESET: begin
                    seq_r <= ST_PROBEH;
                    cnt_r <= 4'h0;
                end
                ST_PROBEH, ST_PROBEL: begin
                    // wait for pulls to settle before sampling
                    if (cnt_r == PROBE_N + 4'h3) begin
                        seq_r <= (seq_r == ST_PROBEH) ? ST_PROBEL : ST_LOAD;
                        cnt_r <= 4'h0;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_LOAD: begin
                    if (loader_done_i) seq_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (req_dev_s) begin
                        seq_r <= ST_HOLD;
                        cnt_r <= 4'h0;
                    end
                end
                ST_HOLD: begin
                    if (cnt_r == HOLD_N - 4'h1) seq_r <= ST_RESET;
                    else cnt_r <= cnt_r + 4'h1;
                end
                default: seq_r <= ST_RESET;
            endcase
        end
    end

    // capture tri-level pins: pull-up read, then pull-down read
    // extra 3 cycles cover the synchroniser latency
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            hi_r        <= 3'h0;
            boot_mode_o <= '{src: BOOT_NONE, usb_fb: 1'b0, valid: 1'b0};
        end else if (seq_r == ST_PROBEH && cnt_r == PROBE_N + 4'h3) begin
            hi_r <= pin_s;
        end else if (seq_r == ST_PROBEL && cnt_r == PROBE_N + 4'h3) begin
            // held until a hard reset, or until recaptured here after a device soft reset
            boot_mode_o <= decode_mode({hi_r[2] & ~pin_s[2], hi_r[2] & pin_s[2],
                                        hi_r[1] & ~pin_s[1], hi_r[1] & pin_s[1],
                                        hi_r[0] & ~pin_s[0], hi_r[0] & pin_s[0]});
        end
    end

    // pulls: up in first probe, down in second
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_pull_en_o <= 3'h0;
            mode_pull_up_o <= 3'h0;
        end else begin
            mode_pull_en_o <= {3{seq_r == ST_PROBEH || seq_r == ST_PROBEL}};
            mode_pull_up_o <= {3{seq_r == ST_PROBEH}};
        end
    end

    // active source with usb fallback on failure
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || seq_r == ST_RESET) begin
            active_src_o <= BOOT_NONE;
            fb_used_r    <= 1'b0;
        end else if (seq_r == ST_PROBEL && cnt_r == PROBE_N + 4'h3) begin
            active_src_o <= BOOT_NONE;
        end else if (seq_r == ST_LOAD && active_src_o == BOOT_NONE && !fb_used_r) begin
            active_src_o <= boot_mode_o.src;
        end else if (seq_r == ST_LOAD && loader_fail_i && boot_mode_o.usb_fb && !fb_used_r) begin
            active_src_o <= BOOT_USB;
            fb_used_r    <= 1'b1;
        end
    end

    // io gating and loader ownership
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            io_oe_allow_o <= 1'b0;
            loader_run_o  <= 1'b0;
        end else begin
            io_oe_allow_o <= (seq_r == ST_LOAD || seq_r == ST_RUN);
            loader_run_o  <= (seq_r == ST_LOAD);
        end
    end

    // cpu reset: held outside run, pulsed by cpu soft reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cpu_rst_n_o <= 1'b0;
        end else begin
            cpu_rst_n_o <= (seq_r == ST_RUN) && !req_cpu_s && !req_dev_s;
        end
    end

    // firmware retained across cpu reset, lost on device reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fw_valid_o <= 1'b0;
        end else if (seq_r == ST_HOLD || seq_r == ST_RESET) begin
            fw_valid_o <= 1'b0;
        end else if (seq_r == ST_LOAD && loader_done_i) begin
            fw_valid_o <= 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// assertions
    sequence s_dev_req;
        seq_r == ST_RUN && req_dev_s;
    endsequence

    sequence s_tristate;
        !io_oe_allow_o;
    endsequence

    AST_TRISTATE_RST: assert property (@(posedge clk_sys_i) !rst_n_i |=> !io_oe_allow_o)
        else $error("io not tristated after hard reset");
    AST_DEV_TRISTATE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_dev_req |-> ##2 s_tristate)
        else $error("device soft reset did not tristate io");
    AST_DEV_FW_LOST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_dev_req |-> ##2 !fw_valid_o)
        else $error("firmware still valid after device reset");
    AST_CPU_KEEP_FW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (seq_r == ST_RUN && req_cpu_s && !req_dev_s && fw_valid_o) |=> (!cpu_rst_n_o && fw_valid_o))
        else $error("cpu reset lost firmware or did not reset cpu");
    AST_MODE_HELD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (seq_r == ST_RUN || seq_r == ST_LOAD) && $past(seq_r) != ST_PROBEL |-> $stable(boot_mode_o))
        else $error("boot mode changed after capture");
    AST_FALLBACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (seq_r == ST_LOAD && loader_fail_i && boot_mode_o.usb_fb && !fb_used_r
         && active_src_o != BOOT_NONE) |=> active_src_o == BOOT_USB)
        else $error("usb fallback not taken");
    AST_NO_FALLBACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (seq_r == ST_LOAD && !boot_mode_o.usb_fb && active_src_o != BOOT_NONE)
        |=> active_src_o == boot_mode_o.src)
        else $error("source changed without fallback");
    AST_LOADER_IO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        loader_run_o |-> io_oe_allow_o)
        else $error("loader running with io gated");
    AST_PROBE_LEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(seq_r == ST_PROBEH) |-> (seq_r == ST_PROBEH) [*8])
        else $error("probe phase too short");
endmodule : boot_source_and_reset_control

// >>> sim/boot_media_model.sv
`timescale 1ns/1ps
// far side: mode pin pads plus the boot media that feeds the loader
module boot_media_model (
    input  wire logic       clk_sys_i,      // core clock
    input  wire logic       rst_n_i,        // hard reset, active low
    input  wire logic [5:0] pin_cfg_i,      // per pin {float, level}, msb pin first
    input  wire logic [1:0] fail_cnt_i,     // primary failures to report per load
    input  wire logic [2:0] pull_en_i,      // weak pulls from the design
    input  wire logic [2:0] pull_up_i,      // pull direction from the design
    input  wire logic       loader_run_i,   // loader owns the io
    output logic [2:0]      boot_mode_pins_o, // pad levels
    output logic            loader_done_o,  // image fully supplied
    output logic            loader_fail_o   // primary source gave up
);
    logic       tgl_r;                      // stand-in for an undriven pad
    logic [3:0] cnt_r;                      // cycles into the current load
    logic [1:0] fails_left_r;               // failures still to report

    ////////////////////////////////////////////////////////////////////////
    // pads: a floating pin follows the weak pull, else wanders each cycle
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            boot_mode_pins_o[i] = pin_cfg_i[2*i+1] ? (pull_en_i[i] ? pull_up_i[i] : tgl_r) : pin_cfg_i[2*i];
        end
    end

    always @(negedge clk_sys_i) begin
        tgl_r <= ~tgl_r;                    // simulator must not settle it for us
    end

    ////////////////////////////////////////////////////////////////////////
    // media: every load starts afresh, so the image is sent again
    always @(negedge clk_sys_i) begin
        if (!rst_n_i || !loader_run_i) begin
            cnt_r         <= 4'h0;
            fails_left_r  <= fail_cnt_i;
            loader_done_o <= 1'b0;
            loader_fail_o <= 1'b0;
        end else begin
            loader_fail_o <= 1'b0;
            if (!loader_done_o) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (cnt_r == 4'h5 && !loader_done_o) begin
                if (fails_left_r != 2'h0) begin  // primary media dead
                    loader_fail_o <= 1'b1;
                    fails_left_r  <= fails_left_r - 2'h1;
                    cnt_r         <= 4'h0;
                end else begin
                    loader_done_o <= 1'b1;  // held until the loader lets go
                end
            end
        end
    end

    initial begin
        tgl_r = 1'b0;
    end
endmodule : boot_media_model

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    import boot_ctl_pkg::*;
    typedef struct packed {
        logic [5:0]   pins;                 // pin codes
        boot_src_type src;                  // expected primary source
        logic         fb;                   // expected usb fallback
        logic         vld;                  // listed code
    } row_type;

    logic          clk_sys_i = 1'b0;
    logic          rst_n_i   = 1'b0;
    logic [5:0]    pin_cfg   = 6'h00;
    logic [1:0]    fail_cnt  = 2'h0;
    logic [1:0]    init_ctl  = 2'h0;
    logic [2:0]    pins, pull_en, pull_up;
    logic          done, fail, io_oe, cpu_rst_n, fw_valid, run;
    boot_mode_type mode;
    boot_src_type  act;
    int            err_count = 0;
    int            checks    = 0;
    row_type       rows [8];

    always #25 clk_sys_i = ~clk_sys_i;     // 20 MHz

    boot_source_and_reset_control u_boot_source_and_reset_control (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .boot_mode_pins_i(pins),
        .processor_port_init_control_i(init_ctl), .loader_done_i(done), .loader_fail_i(fail),
        .mode_pull_en_o(pull_en), .mode_pull_up_o(pull_up), .io_oe_allow_o(io_oe),
        .cpu_rst_n_o(cpu_rst_n), .fw_valid_o(fw_valid), .boot_mode_o(mode),
        .active_src_o(act), .loader_run_o(run));

    boot_media_model u_boot_media_model (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pin_cfg_i(pin_cfg), .fail_cnt_i(fail_cnt),
        .pull_en_i(pull_en), .pull_up_i(pull_up), .loader_run_i(run),
        .boot_mode_pins_o(pins), .loader_done_o(done), .loader_fail_o(fail));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // bounded wait for the loader phase to reach a level
    task automatic wait_run(input logic lvl);
        int n;
        n = 0;
        while (run !== lvl && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(run, lvl);
    endtask : wait_run

    // hard reset from the system side, io must stay off throughout
    task automatic hard_reset;
        rst_n_i = 1'b0;
        repeat (12) begin
            @(negedge clk_sys_i);
            chk(io_oe, 1'b0);
        end
        rst_n_i = 1'b1;
    endtask : hard_reset

    task automatic check_mode(input row_type r);
        chk(mode.src, r.src);
        chk(mode.usb_fb, r.fb);
        chk(mode.valid, r.vld);
    endtask : check_mode

    // primary media fails n times; the source after the failures is checked
    task automatic fail_case(input row_type r, input logic [1:0] n, input boot_src_type exp);
        @(negedge clk_sys_i);
        pin_cfg  = r.pins;
        fail_cnt = n;
        hard_reset();
        wait_run(1'b1);
        chk(act, r.src);
        repeat (13) @(negedge clk_sys_i);
        chk(act, exp);
        wait_run(1'b0);
    endtask : fail_case

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{6'h20, BOOT_SYNC_MUX, 1'b0, 1'b1};
        rows[1] = '{6'h21, BOOT_ASYNC_MUX, 1'b0, 1'b1};
        rows[2] = '{6'h25, BOOT_USB, 1'b0, 1'b1};
        rows[3] = '{6'h22, BOOT_ASYNC_SRAM, 1'b0, 1'b1};
        rows[4] = '{6'h26, BOOT_I2C, 1'b1, 1'b1};
        rows[5] = '{6'h1a, BOOT_I2C, 1'b0, 1'b1};
        rows[6] = '{6'h09, BOOT_SPI, 1'b1, 1'b1};
        rows[7] = '{6'h00, BOOT_NONE, 1'b0, 1'b0};
        foreach (rows[i]) begin
            @(negedge clk_sys_i);
            pin_cfg  = rows[i].pins;
            fail_cnt = {1'b0, rows[i].fb};                  // fallback rows lose the primary once
            hard_reset();
            // pulls go up for the first probe, then down for the second
            repeat (4) @(negedge clk_sys_i);
            chk(pull_en, 3'h7);
            chk(pull_up, 3'h7);
            repeat (8) @(negedge clk_sys_i);
            chk(pull_en, 3'h7);
            chk(pull_up, 3'h0);
            wait_run(1'b1);
            chk(pull_en, 3'h0);
            chk(io_oe, 1'b1);
            check_mode(rows[i]);
            chk(act, rows[i].src);
            if (rows[i].fb) begin
                // media reports failure six cycles into the load
                repeat (7) @(negedge clk_sys_i);
                chk(act, BOOT_USB);
            end
            wait_run(1'b0);
            chk(fw_valid, 1'b1);
            pin_cfg = 6'h2a;                                // all float now
            repeat (30) @(negedge clk_sys_i);
            check_mode(rows[i]);
        end
        // awkward cases: no fallback for i2c only, a second failure is ignored
        fail_case(rows[5], 2'h1, BOOT_I2C);
        fail_case(rows[4], 2'h2, BOOT_USB);
        // cpu only soft reset keeps firmware
        init_ctl = 2'h1;
        repeat (2) @(negedge clk_sys_i);
        chk(cpu_rst_n, 1'b0);
        chk(fw_valid, 1'b1);
        init_ctl = 2'h0;
        repeat (2) @(negedge clk_sys_i);
        chk(cpu_rst_n, 1'b1);
        // whole device soft reset reprobes the new pin setting
        pin_cfg  = 6'h25;
        fail_cnt = 2'h0;
        init_ctl = 2'h2;
        @(negedge clk_sys_i);
        init_ctl = 2'h0;
        repeat (2) @(negedge clk_sys_i);
        chk(io_oe, 1'b0);
        chk(fw_valid, 1'b0);
        wait_run(1'b1);
        check_mode(rows[2]);
        wait_run(1'b0);
        chk(fw_valid, 1'b1);
        close_out();
    end

    // watchdog: all rows plus soft resets take well under 3000 cycles
    initial begin
        #(50 * 6000);
        err_count++;
        close_out();
    end
endmodule : tb
